//--- rtl/lsc_map.svh
// offsets, field positions and reset values for the lag init and symbol loop config block
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
// processor port byte addresses
`define LSC_ADDR_HOLD0 3'h0
`define LSC_ADDR_HOLD1 3'h1
`define LSC_ADDR_HOLD2 3'h2
`define LSC_ADDR_HOLD3 3'h3
`define LSC_ADDR_DEST 3'h4
`define LSC_ADDR_STATUS 3'h5
// destination codes
`define LSC_DEST_LAG_INIT 8'h0d
`define LSC_DEST_SYM_CFG 8'h0e
// symbol config fields
`define LSC_SHIFT_MSB 12
`define LSC_SHIFT_LSB 11
`define LSC_ORDER_MSB 10
`define LSC_ORDER_LSB 9
// status bits
`define LSC_STAT_DONE 0
`define LSC_STAT_PEND 1
// lag accumulator layout
`define LSC_LAG_LOW_W 8
// reset values
`define LSC_HOLD_RST 32'h0000_0000
`define LSC_CFG_RST 4'h0
`endif

//--- rtl/lsc_pkg.sv
// types for the lag init and symbol loop config block
package lsc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } lsc_bus_t;

  typedef struct packed {
    logic [1:0] shift;
    logic [1:0] order;
  } lsc_sym_cfg_t;

  typedef enum logic [2:0] {
    LD_IDLE = 3'h1,
    LD_PEND = 3'h2,
    LD_DONE = 3'h4
  } lsc_ld_st_t;
endpackage : lsc_pkg

//--- rtl/lsc_top.sv
// lag accumulator init strobe, symbol loop config, error shifter and symbol decisions
`timescale 1ns/1ps
`include "lsc_map.svh"
module lsc_top #(
  parameter int ERR_W = 16,
  parameter int SMP_W = 10
) (
  input wire logic core_clk, // 20 MHz device clock
  input wire logic sys_rst, // async reset, active high
  input wire lsc_pkg::lsc_bus_t bus, // processor byte port request
  output logic [7:0] rdata, // read data, one cycle after rd
  input wire logic cycle_start, // carrier loop filter compute cycle start
  output logic lag_load, // one-cycle lag accumulator load
  output logic [39:0] lag_val, // value loaded into lag accumulator
  output lsc_pkg::lsc_sym_cfg_t sym_cfg, // stored symbol loop fields
  input wire logic err_vld, // sampling error valid
  input wire logic signed [ERR_W-1:0] err_in, // raw sampling error
  output logic err_out_vld, // shifted error valid
  output logic signed [ERR_W-1:0] err_out, // shifted, saturated error
  input wire logic smp_vld, // end-of-symbol samples valid
  input wire logic signed [SMP_W-1:0] smp_i, // end-of-symbol I sample
  input wire logic signed [SMP_W-1:0] smp_q, // end-of-symbol Q sample
  output logic dec_vld, // decisions valid
  output logic [3:0] dec_idx_i, // I symbol index, 0 = most negative
  output logic [3:0] dec_idx_q, // Q symbol index
  output logic signed [SMP_W-1:0] dec_exp_i, // expected I symbol level
  output logic signed [SMP_W-1:0] dec_exp_q // expected Q symbol level
);
  import lsc_pkg::*;

  // shift by code+1 places; clamp rather than wrap so a large error cannot flip sign
  function automatic logic [ERR_W-1:0] sat_shift(input logic [ERR_W-1:0] e, input logic [1:0] code);
    logic [2*ERR_W-1:0] full;
    logic [ERR_W:0] top;
    full = {{ERR_W{e[ERR_W-1]}}, e} << ({1'b0, code} + 3'h1);
    top = full[2*ERR_W-1:ERR_W-1];
    if (top == '0 || top == '1) begin
      sat_shift = full[ERR_W-1:0];
    end else if (e[ERR_W-1]) begin
      sat_shift = {1'b1, {(ERR_W-1){1'b0}}};
    end else begin
      sat_shift = {1'b0, {(ERR_W-1){1'b1}}};
    end
  endfunction : sat_shift

  // offset-binary top bits give the bin among equal slices of -1..+1
  function automatic logic [3:0] dec_index(input logic [SMP_W-1:0] s, input logic [1:0] order);
    logic [SMP_W-1:0] u;
    u = {~s[SMP_W-1], s[SMP_W-2:0]};
    dec_index = u[SMP_W-1 -: 4] >> (2'h3 - order);
  endfunction : dec_index

  // bin centre: keep bin bits, set the next bit, flip back to two's complement
  function automatic logic [SMP_W-1:0] dec_level(input logic [SMP_W-1:0] s, input logic [1:0] order);
    logic [SMP_W-1:0] u;
    logic [SMP_W-1:0] mask;
    logic [SMP_W-1:0] half;
    u = {~s[SMP_W-1], s[SMP_W-2:0]};
    mask = ~({SMP_W{1'b1}} >> ({1'b0, order} + 3'h1));
    half = {SMP_W{1'b1}} >> ({1'b0, order} + 3'h1);
    u = (u & mask) | (half & ~(half >> 1));
    dec_level = {~u[SMP_W-1], u[SMP_W-2:0]};
  endfunction : dec_level

  logic [31:0] hold_r;
  logic [31:0] hold_nxt;
  lsc_ld_st_t ld_st_r;
  lsc_ld_st_t ld_st_nxt;
  logic [7:0] rdata_nxt;
  lsc_sym_cfg_t cfg_nxt;

  wire wr_hold = bus.wr && (bus.addr <= `LSC_ADDR_HOLD3);
  wire wr_dest = bus.wr && (bus.addr == `LSC_ADDR_DEST);
  wire wr_lag = wr_dest && (bus.wdata == `LSC_DEST_LAG_INIT);
  wire wr_cfg = wr_dest && (bus.wdata == `LSC_DEST_SYM_CFG);
  wire ld_pend = (ld_st_r == LD_PEND);
  wire ld_done = (ld_st_r == LD_DONE);
  // a write in the start cycle merges with the load; holding regs are the same either way
  wire load_go = cycle_start && (ld_pend || wr_lag);

  always_comb begin
    hold_nxt = hold_r;
    if (wr_hold) begin
      hold_nxt[bus.addr[1:0]*8 +: 8] = bus.wdata;
    end
  end

  always_comb begin
    case (ld_st_r)
      LD_IDLE, LD_PEND, LD_DONE: begin
        if (load_go) begin
          ld_st_nxt = LD_DONE;
        end else if (wr_lag) begin
          ld_st_nxt = LD_PEND;
        end else begin
          ld_st_nxt = ld_st_r;
        end
      end
      default: ld_st_nxt = LD_IDLE;
    endcase
  end

  // reserved bits 15-13 and unused 31-16 are simply not stored
  assign cfg_nxt = wr_cfg ? lsc_sym_cfg_t'({hold_r[`LSC_SHIFT_MSB:`LSC_SHIFT_LSB],
                                            hold_r[`LSC_ORDER_MSB:`LSC_ORDER_LSB]}) : sym_cfg;

  assign rdata_nxt = (bus.addr == `LSC_ADDR_STATUS) ? {6'h00, ld_pend, ld_done} :
                     (bus.addr <= `LSC_ADDR_HOLD3) ? hold_r[bus.addr[1:0]*8 +: 8] : 8'h00;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r <= `LSC_HOLD_RST;
      ld_st_r <= LD_IDLE;
      sym_cfg <= `LSC_CFG_RST;
      rdata <= 8'h00;
    end else begin
      hold_r <= hold_nxt;
      ld_st_r <= ld_st_nxt;
      sym_cfg <= cfg_nxt;
      if (bus.rd) begin
        rdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lag_load <= 1'b0;
      lag_val <= 40'h00_0000_0000;
    end else begin
      lag_load <= load_go;
      if (load_go) begin
        lag_val <= {hold_r, {`LSC_LAG_LOW_W{1'b0}}};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_out_vld <= 1'b0;
      err_out <= '0;
      dec_vld <= 1'b0;
      dec_idx_i <= 4'h0;
      dec_idx_q <= 4'h0;
      dec_exp_i <= '0;
      dec_exp_q <= '0;
    end else begin
      err_out_vld <= err_vld;
      if (err_vld) begin
        err_out <= sat_shift(err_in, sym_cfg.shift);
      end
      dec_vld <= smp_vld;
      if (smp_vld) begin
        dec_idx_i <= dec_index(smp_i, sym_cfg.order);
        dec_idx_q <= dec_index(smp_q, sym_cfg.order);
        dec_exp_i <= dec_level(smp_i, sym_cfg.order);
        dec_exp_q <= dec_level(smp_q, sym_cfg.order);
      end
    end
  end

  // checks
  load_on_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ld_pend && cycle_start) |=> (lag_load && lag_val[39:8] == $past(hold_r)))
    else $error("pending lag load not done at compute start");
  no_load_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(cycle_start) |-> !lag_load)
    else $error("lag load outside a compute start");
  lag_low_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    lag_load |-> (lag_val[7:0] == 8'h00))
    else $error("lag accumulator low byte not cleared");
  done_after_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    lag_load |-> ld_done)
    else $error("done flag missing after lag load");
  done_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_lag && !cycle_start) |=> (!ld_done && ld_pend) ##1 (ld_pend || ld_done))
    else $error("lag init write did not clear done");
  status_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (bus.rd && bus.addr == `LSC_ADDR_STATUS) |=> (rdata[`LSC_STAT_DONE] == $past(ld_done)))
    else $error("status read does not show done flag");
  sat_sign_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    err_out_vld && $past(err_in) != '0 |-> (err_out[ERR_W-1] == $past(err_in[ERR_W-1])))
    else $error("shifted error wrapped sign");
  shift_x2_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (err_vld && sym_cfg.shift == 2'h0 && err_in[ERR_W-1] == err_in[ERR_W-2]) |=>
    (err_out == ($past(err_in) <<< 1)))
    else $error("x2 shift wrong");
  order_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_cfg |=> (sym_cfg.order == $past(hold_r[`LSC_ORDER_MSB:`LSC_ORDER_LSB])))
    else $error("modulation order not taken");
  idx_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dec_vld |-> ((dec_idx_i >> ({1'b0, $past(sym_cfg.order)} + 3'h1)) == 4'h0))
    else $error("decision index beyond order");
  zero_thresh_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dec_vld |-> (dec_exp_q[SMP_W-1] == $past(smp_q[SMP_W-1])))
    else $error("zero threshold not honoured");
  merge_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_lag && cycle_start) |=> (lag_load && ld_done && lag_val[39:8] == $past(hold_r)))
    else $error("lag write at compute start not loaded");

  load_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) wr_lag ##[1:20] lag_load);
  sat_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    err_out_vld && sym_cfg.shift == 2'h3 && err_out == {1'b0, {(ERR_W-1){1'b1}}});
  order16_c: cover property (@(posedge core_clk) disable iff (sys_rst) dec_vld && dec_idx_i == 4'hf);
  merge_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) wr_lag && cycle_start);
endmodule : lsc_top

//--- testbench/lsc_host.sv
// host processor model for the byte-wide control port
`timescale 1ns/1ps
module lsc_host (
  input wire logic core_clk, // device clock
  output lsc_pkg::lsc_bus_t bus, // byte port request
  input wire logic [7:0] rdata // read data
);
  import lsc_pkg::*;
  initial bus = '0;
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus.wr <= 1'b0;
    // released data must not keep its last value
    bus.wdata <= ~d;
  endtask : wr
  task automatic put(input logic [31:0] w, input logic [7:0] dest);
    for (int i = 0; i < 4; i++) wr(3'(i), w[8*i +: 8]);
    wr(3'h4, dest);
  endtask : put
  task automatic get(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: bus.wdata};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : get
endmodule : lsc_host

//--- testbench/lag_init_and_symbol_loop_config_tb.sv
// self-checking bench for the lag init strobe and symbol loop config block
`timescale 1ns/1ps
module lag_init_and_symbol_loop_config_tb;
  import lsc_pkg::*;
  localparam int EW = 16;
  localparam int SW = 10;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cycle_start = 1'b0;
  logic err_vld = 1'b0;
  logic smp_vld = 1'b0;
  logic signed [EW-1:0] err_in = '0;
  logic signed [SW-1:0] smp_i = '0;
  logic signed [SW-1:0] smp_q = '0;
  lsc_bus_t bus;
  lsc_sym_cfg_t sym_cfg;
  logic [7:0] rdata;
  logic lag_load, err_out_vld, dec_vld;
  logic [39:0] lag_val;
  logic signed [EW-1:0] err_out;
  logic signed [SW-1:0] dec_exp_i, dec_exp_q;
  logic [3:0] dec_idx_i, dec_idx_q;
  logic [31:0] seed = 32'h0000_2075;
  logic [39:0] q_lag[$], q_err[$], q_dec[$];
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  initial forever #25 core_clk = ~core_clk;
  lsc_top #(.ERR_W(EW), .SMP_W(SW)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .cycle_start(cycle_start), .lag_load(lag_load), .lag_val(lag_val), .sym_cfg(sym_cfg), .err_vld(err_vld),
    .err_in(err_in), .err_out_vld(err_out_vld), .err_out(err_out), .smp_vld(smp_vld), .smp_i(smp_i),
    .smp_q(smp_q), .dec_vld(dec_vld), .dec_idx_i(dec_idx_i), .dec_idx_q(dec_idx_q), .dec_exp_i(dec_exp_i),
    .dec_exp_q(dec_exp_q));
  lsc_host host (.core_clk(core_clk), .bus(bus), .rdata(rdata));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [EW-1:0] sat(logic [1:0] sh, logic signed [EW-1:0] e);
    longint v;
    v = longint'(e) <<< (sh + 1);
    if (v > 2**(EW-1) - 1) v = 2**(EW-1) - 1;
    if (v < -(2**(EW-1))) v = -(2**(EW-1));
    return EW'(v);
  endfunction : sat
  // index from offset binary, level at the bin centre
  function automatic logic [13:0] dec1(logic [1:0] o, logic [SW-1:0] s);
    logic [SW-1:0] idx, lv;
    idx = {~s[SW-1], s[SW-2:0]} >> (SW - 1 - o);
    lv = (((idx << 1) + 1) << (SW - 2 - o)) - (1 << (SW - 1));
    return {idx[3:0], lv};
  endfunction : dec1
  task automatic check(string nm, logic [39:0] seen, logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic pulse();
    @(posedge core_clk);
    cycle_start <= 1'b1;
    @(posedge core_clk);
    cycle_start <= 1'b0;
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // an output with no note pending compares against unknown and fails
  always @(negedge core_clk) begin
    if (lag_load === 1'b1) check("lag_val", lag_val, q_lag.size() ? q_lag.pop_front() : 'x);
    if (err_out_vld === 1'b1) check("err_out", $unsigned(err_out), q_err.size() ? q_err.pop_front() : 'x);
    if (dec_vld === 1'b1) check("dec", {dec_idx_i, dec_exp_i, dec_idx_q, dec_exp_q},
      q_dec.size() ? q_dec.pop_front() : 'x);
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] w;
    logic [7:0] d;
    logic [1:0] sh, od;
    logic signed [EW-1:0] e;
    logic [SW-1:0] si, sq;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    w = xs();
    host.put(w, 8'h0d);
    host.get(3'h5, d);
    check("status pending", d, 8'h02);
    q_lag.push_back({w, 8'h00});
    pulse();
    host.get(3'h5, d);
    check("status done", d, 8'h01);
    pulse();
    host.get(3'h6, d);
    check("unmapped read", d, 8'h00);
    // a second request while done must clear done until the next start
    w = xs();
    host.put(w, 8'h0d);
    host.get(3'h5, d);
    check("status cleared", d, 8'h02);
    q_lag.push_back({w, 8'h00});
    pulse();
    host.get(3'h5, d);
    check("status reloaded", d, 8'h01);
    // request landing on the compute start edge loads at once
    w = xs();
    for (int i = 0; i < 4; i++) host.wr(3'(i), w[8*i +: 8]);
    q_lag.push_back({w, 8'h00});
    fork
      host.wr(3'h4, 8'h0d);
      pulse();
    join
    host.get(3'h5, d);
    check("status merged", d, 8'h01);
    $display("lag load test done");
    for (int k = 0; k < 16; k++) begin
      sh = k[3:2];
      od = k[1:0];
      w = xs();
      host.put({w[31:16], 3'b000, sh, od, w[8:0]}, 8'h0e);
      repeat (2) @(posedge core_clk);
      check("sym_cfg", sym_cfg, {sh, od});
      for (int j = 0; j < 4; j++) begin
        w = xs();
        e = $signed(w[15:0]) >>> (4 * j);
        si = (j == 0) ? '0 : w[25:16];
        sq = w[31:22];
        @(posedge core_clk);
        err_vld <= 1'b1;
        smp_vld <= 1'b1;
        err_in <= e;
        smp_i <= si;
        smp_q <= sq;
        q_err.push_back(sat(sh, e));
        q_dec.push_back({dec1(od, si), dec1(od, sq)});
      end
      @(posedge core_clk);
      err_vld <= 1'b0;
      smp_vld <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
    $display("config sweep done");
    check("notes left", q_lag.size() + q_err.size() + q_dec.size(), 0);
    wrap_up();
  end
endmodule : lag_init_and_symbol_loop_config_tb
